// ### hw/fsr_status_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.vh"

module fsr_status_regs #(
    parameter [7:0] DIE_TYPE = `FSR_DIE_TYPE_DEFAULT, // Arbitrary value
    parameter [3:0] VARIANT = `FSR_VARIANT_DEFAULT, // Arbitrary value
    parameter [3:0] REVISION = `FSR_REVISION_DEFAULT // Arbitrary value
) (
    input wire i_clk, // 40 MHz system clock
    input wire i_rstn, // Synchronous reset, active low
    input wire i_rd_stb, // One-cycle read strobe from serial engine
    input wire [7:0] i_rd_addr, // Register address of read
    output reg [7:0] o_rd_data, // Read data, valid cycle after strobe
    output reg o_rd_valid, // Pulse marking o_rd_data
    input wire i_thermistor_short, // Thermistor input shorted
    input wire i_blank_event, // Transmit-blank event seen
    input wire i_output_window_fault, // Output outside good window
    input wire i_die_overtemp, // Die over-temperature
    input wire i_thermistor_trip, // Thermistor threshold tripped
    input wire i_indicator_led_fault, // Indicator LED open/short
    input wire i_flash_led_two_fault, // Second flash LED open/short
    input wire i_flash_led_one_fault, // First flash LED open/short
    input wire i_low_battery_reduction, // Low-battery reduction active
    input wire i_blank_current_limit // Input limit reached in blanking
);

    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    // Count of detector lines entering the block
    localparam NUM_COND = 10;

    // Width of the read data bus
    localparam DATA_WIDTH = 8;

    // Reserved low part of the event register
    localparam RSV_WIDTH = DATA_WIDTH - `FSR_EVENT_WIDTH;

    // Slot of each detector in the synchroniser vectors
    localparam SYN_FLED_ONE = 0;
    localparam SYN_FLED_TWO = 1;
    localparam SYN_IND_LED = 2;
    localparam SYN_THERM_TRIP = 3;
    localparam SYN_DIE_OVERTEMP = 4;
    localparam SYN_OUT_WINDOW = 5;
    localparam SYN_BLANK_EVENT = 6;
    localparam SYN_THERM_SHORT = 7;
    localparam SYN_LOW_BATT = 8;
    localparam SYN_BLANK_ILIM = 9;

    // ----------------------------------------
    // Timing summary
    // ----------------------------------------
    // Pin to flag: two synchroniser clocks, the flag register on the third
    // Strobe to answer: exactly one clock, valid for that one clock only
    // Read data holds between strobes; valid marks the fresh word
    // A read clears only the flags it returned, never a same-cycle set
    // A condition still high in the second stage sets its flag again
    // So a condition that has just dropped may survive one more read
    // Back-to-back strobes are allowed on every clock
    // Identity reads have no side effect at all

    // ----------------------------------------
    // Detector gathering
    // ----------------------------------------
    wire [NUM_COND-1:0] raw_cond;

    // Fault detectors, one slot each
    assign raw_cond[SYN_FLED_ONE] = i_flash_led_one_fault;
    assign raw_cond[SYN_FLED_TWO] = i_flash_led_two_fault;
    assign raw_cond[SYN_IND_LED] = i_indicator_led_fault;
    assign raw_cond[SYN_THERM_TRIP] = i_thermistor_trip;
    assign raw_cond[SYN_DIE_OVERTEMP] = i_die_overtemp;
    assign raw_cond[SYN_OUT_WINDOW] = i_output_window_fault;
    assign raw_cond[SYN_BLANK_EVENT] = i_blank_event;
    assign raw_cond[SYN_THERM_SHORT] = i_thermistor_short;

    // Event detectors for the second status register
    assign raw_cond[SYN_LOW_BATT] = i_low_battery_reduction;
    assign raw_cond[SYN_BLANK_ILIM] = i_blank_current_limit;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Detectors are analog and asynchronous, so two stages before use
    // Limitation: a condition narrower than one clock period may be missed
    wire [NUM_COND-1:0] sync_cond;

    genvar s;
    generate
        for (s = 0; s < NUM_COND; s = s + 1) begin : g_sync
            reg sync1_reg;
            reg sync2_reg;

            // First stage feeds only the second
            always @(posedge i_clk) begin
                if (!i_rstn) begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                end else begin
                    sync1_reg <= raw_cond[s];
                    sync2_reg <= sync1_reg;
                end
            end

            // Only the second stage leaves the chain
            assign sync_cond[s] = sync2_reg;
        end
    endgenerate

    // ----------------------------------------
    // Condition mapping onto flag positions
    // ----------------------------------------
    // Each flag is set from the second stage only, on the third clock after its pin
    wire [`FSR_FAULT_WIDTH-1:0] fault_cond;
    wire [`FSR_EVENT_WIDTH-1:0] event_cond;

    // Thermal faults
    assign fault_cond[`FSR_BIT_THERM_SHORT] = sync_cond[SYN_THERM_SHORT];
    assign fault_cond[`FSR_BIT_DIE_OVERTEMP] = sync_cond[SYN_DIE_OVERTEMP];
    assign fault_cond[`FSR_BIT_THERM_TRIP] = sync_cond[SYN_THERM_TRIP];

    // Supply and blanking faults
    assign fault_cond[`FSR_BIT_BLANK_EVENT] = sync_cond[SYN_BLANK_EVENT];
    assign fault_cond[`FSR_BIT_OUT_WINDOW] = sync_cond[SYN_OUT_WINDOW];

    // LED regulator faults
    assign fault_cond[`FSR_BIT_IND_LED] = sync_cond[SYN_IND_LED];
    assign fault_cond[`FSR_BIT_FLED_TWO] = sync_cond[SYN_FLED_TWO];
    assign fault_cond[`FSR_BIT_FLED_ONE] = sync_cond[SYN_FLED_ONE];

    // Event bank bit 1 is register bit 7, bit 0 is register bit 6
    assign event_cond[1] = sync_cond[SYN_LOW_BATT];
    assign event_cond[0] = sync_cond[SYN_BLANK_ILIM];

    // ----------------------------------------
    // Read decode and clear strobes
    // ----------------------------------------
    wire hit_fault;
    wire hit_event;
    wire hit_die;
    wire hit_variant;
    wire rd_fault;
    wire rd_event;

    // Address compare per register
    // Exact match on the whole byte, so nothing aliases
    assign hit_fault = (i_rd_addr == `FSR_ADDR_FAULT_STATUS);
    assign hit_event = (i_rd_addr == `FSR_ADDR_EVENT_STATUS);
    assign hit_die = (i_rd_addr == `FSR_ADDR_DIE_TYPE);
    assign hit_variant = (i_rd_addr == `FSR_ADDR_VARIANT_REV);

    // A read clears only the register it names
    assign rd_fault = i_rd_stb & hit_fault;
    assign rd_event = i_rd_stb & hit_event;

    // ----------------------------------------
    // Sticky flag banks
    // ----------------------------------------
    // Latched flags, one bank per status register
    wire [`FSR_FAULT_WIDTH-1:0] fault_flags;
    wire [`FSR_EVENT_WIDTH-1:0] event_flags;

    // Fault bank, cleared by a read of its own address
    fsr_flag_latch #(
        .WIDTH(`FSR_FAULT_WIDTH)
    ) u_fault_latch (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_cond(fault_cond),
        .i_clear(rd_fault),
        .o_flags(fault_flags)
    );

    // Event bank, cleared independently of the fault bank
    fsr_flag_latch #(
        .WIDTH(`FSR_EVENT_WIDTH)
    ) u_event_latch (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_cond(event_cond),
        .i_clear(rd_event),
        .o_flags(event_flags)
    );

    // ----------------------------------------
    // Named flag views
    // ----------------------------------------
    // One name per status bit keeps the read packing easy to audit
    // Fault bank
    wire thermistor_short_flag;
    wire transmit_blank_event_flag;
    wire output_window_fault_flag;
    wire die_overtemp_flag;
    wire thermistor_trip_flag;
    wire indicator_led_fault_flag;
    wire flash_led_two_fault_flag;
    wire flash_led_one_fault_flag;

    // Event bank
    wire low_battery_reduction_flag;
    wire blank_current_limit_flag;

    // Fault bank bits
    assign thermistor_short_flag = fault_flags[`FSR_BIT_THERM_SHORT];
    assign transmit_blank_event_flag = fault_flags[`FSR_BIT_BLANK_EVENT];
    assign output_window_fault_flag = fault_flags[`FSR_BIT_OUT_WINDOW];
    assign die_overtemp_flag = fault_flags[`FSR_BIT_DIE_OVERTEMP];
    assign thermistor_trip_flag = fault_flags[`FSR_BIT_THERM_TRIP];
    assign indicator_led_fault_flag = fault_flags[`FSR_BIT_IND_LED];
    assign flash_led_two_fault_flag = fault_flags[`FSR_BIT_FLED_TWO];
    assign flash_led_one_fault_flag = fault_flags[`FSR_BIT_FLED_ONE];

    // Event bank bits
    assign low_battery_reduction_flag = event_flags[1];
    assign blank_current_limit_flag = event_flags[0];

    // ----------------------------------------
    // Per-register read values
    // ----------------------------------------
    // Packed exactly as the host sees each register
    wire [7:0] fault_rd_value;
    wire [7:0] event_rd_value;
    wire [7:0] die_rd_value;
    wire [7:0] variant_rd_value;

    // Fault flags as they stood before the clear of this read
    assign fault_rd_value = {thermistor_short_flag, transmit_blank_event_flag,
                             output_window_fault_flag, die_overtemp_flag,
                             thermistor_trip_flag, indicator_led_fault_flag,
                             flash_led_two_fault_flag, flash_led_one_fault_flag};

    // Reserved event bits are tied low
    assign event_rd_value = {low_battery_reduction_flag, blank_current_limit_flag,
                             {RSV_WIDTH{1'b0}}};

    // Identity values are wired from parameters, so neither writes nor reset reach them
    assign die_rd_value = DIE_TYPE;
    assign variant_rd_value = {VARIANT, REVISION};

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    reg [7:0] rd_mux;

    // Unmapped addresses answer zero rather than echo a neighbour
    always @* begin
        case ({hit_fault, hit_event, hit_die, hit_variant})
            4'h8: begin
                rd_mux = fault_rd_value;
            end
            4'h4: begin
                rd_mux = event_rd_value;
            end
            4'h2: begin
                rd_mux = die_rd_value;
            end
            4'h1: begin
                rd_mux = variant_rd_value;
            end
            default: begin
                rd_mux = `FSR_READ_ZERO;
            end
        endcase
    end

    // ----------------------------------------
    // Registered answer
    // ----------------------------------------
    // Valid pulses once for every strobe, one clock later
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_stb;
        end
    end

    // Data holds the last answer until the next strobe, so a slow host can still take it
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rd_data <= `FSR_READ_ZERO;
        end else if (i_rd_stb) begin
            o_rd_data <= rd_mux;
        end
    end

endmodule // fsr_status_regs

`default_nettype wire

// ### shared/fsr_defines.vh
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// Register offsets
`define FSR_ADDR_FAULT_STATUS 8'h17
`define FSR_ADDR_EVENT_STATUS 8'h18
`define FSR_ADDR_DIE_TYPE 8'h1a
`define FSR_ADDR_VARIANT_REV 8'h1b

// Fault status bit positions
`define FSR_BIT_THERM_SHORT 7
`define FSR_BIT_BLANK_EVENT 6
`define FSR_BIT_OUT_WINDOW 5
`define FSR_BIT_DIE_OVERTEMP 4
`define FSR_BIT_THERM_TRIP 3
`define FSR_BIT_IND_LED 2
`define FSR_BIT_FLED_TWO 1
`define FSR_BIT_FLED_ONE 0

// Event status bit positions
`define FSR_BIT_LOW_BATT 7
`define FSR_BIT_BLANK_ILIM 6

// Reset and fixed values
`define FSR_STATUS_RESET 8'h00
`define FSR_READ_ZERO 8'h00
`define FSR_FAULT_WIDTH 8
`define FSR_EVENT_WIDTH 2

// Identity defaults: arbitrary neutral values
`define FSR_DIE_TYPE_DEFAULT 8'h42
`define FSR_VARIANT_DEFAULT 4'h0
`define FSR_REVISION_DEFAULT 4'h3

`endif

// ### hw/fsr_flag_latch.v
`timescale 1ns/1ps
`default_nettype none

// Bank of sticky flags with clear-on-read; set wins over clear
module fsr_flag_latch #(
    parameter WIDTH = 8
) (
    input wire i_clk, // System clock
    input wire i_rstn, // Synchronous reset, active low
    input wire [WIDTH-1:0] i_cond, // Synchronised raw conditions
    input wire i_clear, // Read of this register clears
    output wire [WIDTH-1:0] o_flags // Latched flags
);

    reg [WIDTH-1:0] flag_reg;
    wire [WIDTH-1:0] flag_next;

    // ----------------------------------------
    // Per-bit latch
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            // A live condition sets again after a clear, and beats it
            assign flag_next[g] = i_cond[g] | (flag_reg[g] & ~i_clear);
        end
    endgenerate

    // Flags update every clock
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            flag_reg <= {WIDTH{1'b0}};
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign o_flags = flag_reg;

endmodule // fsr_flag_latch

`default_nettype wire

// ### verif/fsr_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Read checks
// ----
module fsr_asserts #(
    parameter [7:0] DIE_TYPE = 8'h00,
    parameter [3:0] VARIANT = 4'h0,
    parameter [3:0] REVISION = 4'h0
) (
    input wire logic i_clk, // Clk
    input wire logic i_rstn, // Rst
    input wire logic i_rd_stb, // Stb
    input wire logic [7:0] i_rd_addr, // Addr
    input wire logic [7:0] o_rd_data, // Data
    input wire logic o_rd_valid, // Valid
    input wire logic i_thermistor_short, // F7
    input wire logic i_blank_event, // F6
    input wire logic i_output_window_fault, // F5
    input wire logic i_die_overtemp, // F4
    input wire logic i_thermistor_trip, // F3
    input wire logic i_indicator_led_fault, // F2
    input wire logic i_flash_led_two_fault, // F1
    input wire logic i_flash_led_one_fault, // F0
    input wire logic i_low_battery_reduction, // E7
    input wire logic i_blank_current_limit // E6
);
    // Faults in bit order; a quiet bank must read back empty
    wire logic [7:0] flt = {i_thermistor_short, i_blank_event, i_output_window_fault, i_die_overtemp,
        i_thermistor_trip, i_indicator_led_fault, i_flash_led_two_fault, i_flash_led_one_fault};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_rd(a); i_rd_stb && i_rd_addr == a; endsequence
    sequence s_held; i_thermistor_short [*4] ##1 !i_rd_stb; endsequence
    property p_ans; i_rd_stb |=> o_rd_valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_rsv; s_rd(8'h18) |=> o_rd_data[5:0] == 6'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    property p_unm; i_rd_stb && !(i_rd_addr inside {8'h17, 8'h18, 8'h1a, 8'h1b}) |=> o_rd_data == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped data");
    property p_die; s_rd(8'h1a) |=> o_rd_data == DIE_TYPE; endproperty
    a_die: assert property (p_die) else $error("die type");
    property p_var; s_rd(8'h1b) |=> o_rd_data == {VARIANT, REVISION}; endproperty
    a_var: assert property (p_var) else $error("variant");
    property p_stk; s_held ##1 s_rd(8'h17) |=> o_rd_data[7]; endproperty
    a_stk: assert property (p_stk) else $error("flag lost");
    property p_per; i_die_overtemp [*4] ##1 s_rd(8'h17) ##1 s_rd(8'h17) |=> o_rd_data[4]; endproperty
    a_per: assert property (p_per) else $error("no reset");
    property p_clr; (flt == 8'h00) [*4] ##0 s_rd(8'h17) ##1 s_rd(8'h17) |=> o_rd_data == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("not cleared");
endmodule // fsr_asserts
`default_nettype wire

// ### verif/fsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
    input wire logic i_clk, // Clk
    input wire logic [7:0] i_rd_data, // Data
    input wire logic i_rd_valid, // Valid
    output logic o_rd_stb = 1'b0, // Stb
    output logic [7:0] o_rd_addr = 8'h00 // Addr
);
    // n back-to-back reads; the address is scrambled once released
    task rd(input [7:0] a, input int n, output [7:0] d, output logic ok);
        ok = 1'b1;
        @(posedge i_clk); #1;
        o_rd_stb = 1'b1;
        o_rd_addr = a;
        repeat (n) begin
            @(posedge i_clk); #1;
            ok = ok & i_rd_valid;
        end
        d = i_rd_data;
        o_rd_stb = 1'b0;
        o_rd_addr = ~a;
    endtask
endmodule // fsr_host_model
`default_nettype wire

// ### verif/fsr_status_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_status_regs_tb;
    localparam [7:0] DT = 8'h36; // Arbitrary value
    localparam [3:0] VR = 4'h1; // Arbitrary value
    localparam [3:0] RV = 4'h7; // Arbitrary value
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_thermistor_short, i_blank_event, i_output_window_fault, i_die_overtemp, i_thermistor_trip;
    logic i_indicator_led_fault, i_flash_led_two_fault, i_flash_led_one_fault;
    logic i_low_battery_reduction, i_blank_current_limit;
    wire logic i_rd_stb, o_rd_valid;
    wire logic [7:0] i_rd_addr, o_rd_data;
    int mismatches = 0;
    int cmp_count = 0;
    always #12.5 i_clk = ~i_clk;
    fsr_status_regs #(.DIE_TYPE(DT), .VARIANT(VR), .REVISION(RV)) i_fsr_status_regs (.*);
    fsr_host_model i_fsr_host_model (.i_clk(i_clk), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid),
        .o_rd_stb(i_rd_stb), .o_rd_addr(i_rd_addr));
    task setc(input [9:0] v);
        {i_thermistor_short, i_blank_event, i_output_window_fault, i_die_overtemp, i_thermistor_trip,
            i_indicator_led_fault, i_flash_led_two_fault, i_flash_led_one_fault,
            i_low_battery_reduction, i_blank_current_limit} = v;
    endtask
    task chk(input string n, input [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task rd(input [7:0] a, input int n, output [7:0] d);
        logic ok;
        i_fsr_host_model.rd(a, n, d, ok);
        chk("valid", 8'h01, {7'h00, ok});
    endtask
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task t_ids;
        logic [7:0] d;
        rd(8'h1a, 1, d); chk("die", DT, d);
        rd(8'h1b, 1, d); chk("var", {VR, RV}, d);
        rd(8'h19, 1, d); chk("unmapped", 8'h00, d);
        rd(8'h17, 1, d); chk("fault", 8'h00, d);
    endtask
    // Each condition pulses, then is gone before the read: the flag must still show
    task t_flags;
        logic [7:0] d, a, e;
        for (int i = 9; i >= 0; i--) begin
            a = (i > 1) ? 8'h17 : 8'h18;
            e = (i > 1) ? 8'h01 << (i - 2) : 8'h40 << i;
            setc(10'h001 << i);
            repeat (4) @(posedge i_clk);
            #1 setc(10'h000);
            rd(a, 1, d); chk("set", e, d);
            rd(a, 2, d); chk("clr", 8'h00, d);
        end
    endtask
    task t_persist;
        logic [7:0] d;
        setc(10'h040);
        repeat (4) @(posedge i_clk);
        rd(8'h17, 2, d); chk("held", 8'h10, d);
        setc(10'h000);
        repeat (3) @(posedge i_clk); // Let the synchroniser drain so the next clear is final
        rd(8'h17, 1, d); chk("kept", 8'h10, d);
        rd(8'h17, 1, d); chk("gone", 8'h00, d);
    endtask
    initial begin
        setc(10'h000);
        repeat (16) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        t_ids;
        t_flags;
        t_persist;
        i_rstn = 1'b0;
        repeat (3) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        t_ids;
        finish_test;
    end
    // Watchdog: the run needs well under 400 cycles
    initial begin
        #(2000 * 25);
        mismatches++;
        finish_test;
    end
endmodule // fsr_status_regs_tb
bind fsr_status_regs fsr_asserts #(.DIE_TYPE(DIE_TYPE), .VARIANT(VARIANT), .REVISION(REVISION)) i_fsr_asserts (.*);
`default_nettype wire
